// ---- ext_control_io.v ----
// external control port: triggers, requests and active-low result outputs
`timescale 1ns/1ps
`include "ext_io_defs.vh"
module ext_control_io
#(
  parameter CLK_HZ       = `CLK_HZ,
  parameter CAL60_CYCLES = (`CAL_60HZ_MS * (CLK_HZ / 1000)),
  parameter CAL50_CYCLES = (`CAL_50HZ_MS * (CLK_HZ / 1000)),
  parameter PRB_CYCLES   = (`PRB_DELAY_MS * (CLK_HZ / 1000))
)
(
  input  wire                 clk,
  input  wire                 rst_n,
  input  wire                 wb_cyc_i,
  input  wire                 wb_stb_i,
  input  wire                 wb_we_i,
  input  wire [`WB_AW-1:0]    wb_adr_i,
  input  wire [3:0]           wb_sel_i,
  input  wire [31:0]          wb_dat_i,
  output reg  [31:0]          wb_dat_o,
  output reg                  wb_ack_o,
  input  wire                 measure_start_in_n,
  input  wire                 trigger_override_in_n,
  input  wire                 panel_lock_in_n,
  input  wire                 zero_null_in,
  input  wire                 report_request_in_n,
  input  wire                 autotrim_request_in_n,
  input  wire                 probe_short_test_in,
  output reg                  measure_done_out,
  output reg                  sampling_done_out,
  output reg                  fault_out,
  output reg                  above_limit_out,
  output reg                  in_limit_out,
  output reg                  under_limit_out,
  output reg                  plus_side_contact_fault_out,
  output reg                  minus_side_contact_fault_out,
  output reg                  probe_short_fault_out,
  output reg                  measure_go,
  output reg                  stats_store,
  output reg                  memory_store,
  output reg                  zero_go,
  output reg                  print_go,
  output reg                  cal_busy,
  output reg                  probe_check_go,
  output reg                  panel_keys_enabled,
  output reg                  pin_trigger_mode
);
  localparam CW = 24;
  localparam [CW-1:0] CAL60 = CAL60_CYCLES[CW-1:0];
  localparam [CW-1:0] CAL50 = CAL50_CYCLES[CW-1:0];
  localparam [CW-1:0] PRBD  = PRB_CYCLES[CW-1:0];
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_MEAS = 4'b0010;
  localparam [3:0] S_CAL  = 4'b0100;
  localparam [3:0] S_WAIT = 4'b1000;

  wire measure_start_in_fall, measure_start_in_rise;
  wire ovr_lvl, lock_lvl, zero_fall, rep_fall, cal_fall, prb_fall;
  ext_io_edge u_measure_start_in (.clk(clk), .rst_n(rst_n), .pin(measure_start_in_n), .level(),
    .fall(measure_start_in_fall), .rise(measure_start_in_rise));
  ext_io_edge u_ovr  (.clk(clk), .rst_n(rst_n), .pin(trigger_override_in_n), .level(ovr_lvl),
    .fall(), .rise());
  ext_io_edge u_lock (.clk(clk), .rst_n(rst_n), .pin(panel_lock_in_n), .level(lock_lvl),
    .fall(), .rise());
  ext_io_edge u_zero (.clk(clk), .rst_n(rst_n), .pin(zero_null_in), .level(),
    .fall(zero_fall), .rise());
  ext_io_edge u_rep  (.clk(clk), .rst_n(rst_n), .pin(report_request_in_n), .level(),
    .fall(rep_fall), .rise());
  ext_io_edge u_cal  (.clk(clk), .rst_n(rst_n), .pin(autotrim_request_in_n), .level(),
    .fall(cal_fall), .rise());
  ext_io_edge u_prb  (.clk(clk), .rst_n(rst_n), .pin(probe_short_test_in), .level(),
    .fall(prb_fall), .rise());

  reg [7:0]    ctrl;
  reg [7:0]    result;
  reg          monitor_err;
  reg [3:0]    state;
  reg [CW-1:0] count;
  reg          cal_pend;
  reg          prb_pend;
  reg          prb_wait;
  reg [CW-1:0] prb_count;

  wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // writes land on the edge where the master samples ack high
  wire wb_wr    = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire wr_ctrl  = wb_wr & (wb_adr_i == `REG_CTRL);
  wire wr_res   = wb_wr & (wb_adr_i == `REG_RESULT);
  wire wr_cmd   = wb_wr & (wb_adr_i == `REG_CMD);
  wire cmd_done = wr_cmd & wb_dat_i[`CMD_DONE];
  // override low forces pin mode, high restores
  wire pin_mode = ~ovr_lvl | ~ctrl[`CTRL_SELF_TIMED];
  wire sel_edge = ctrl[`CTRL_RISING] ? measure_start_in_rise : measure_start_in_fall;
  wire blocked  = ctrl[`CTRL_MONITOR_EN] & monitor_err;
  // one start per selected edge in pin mode, only when idle, not blocked and no calibration pending
  wire start    = sel_edge & pin_mode & ~blocked & state[0] & ~cal_pend;
  wire busy     = state[1];

  // register file; unmapped addresses read zero and still ack
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
      ctrl        <= `CTRL_RESET;
      result      <= 8'h00;
      monitor_err <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wr_ctrl)
        ctrl <= wb_dat_i[7:0];
      if (wr_res)
        result <= wb_dat_i[7:0];
      // set wins over clear
      if (wr_cmd & wb_dat_i[`CMD_MONITOR_ERR])
        monitor_err <= 1'b1;
      else if (wr_cmd & wb_dat_i[`CMD_MONITOR_CLR])
        monitor_err <= 1'b0;
      case (wb_adr_i)
        `REG_CTRL:   wb_dat_o <= {24'h00_0000, ctrl};
        `REG_STATUS: wb_dat_o <= {24'h00_0000, lock_lvl, prb_pend, cal_pend, monitor_err, state};
        `REG_RESULT: wb_dat_o <= {24'h00_0000, result};
        default:     wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // measurement and calibration sequencing
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state        <= S_IDLE;
      count        <= {CW{1'b0}};
      cal_pend     <= 1'b0;
      measure_go   <= 1'b0;
      stats_store  <= 1'b0;
      memory_store <= 1'b0;
      cal_busy     <= 1'b0;
    end
    else
    begin
      measure_go   <= 1'b0;
      stats_store  <= 1'b0;
      memory_store <= 1'b0;
      if (cal_fall)
        cal_pend <= 1'b1;
      if (sel_edge & ~blocked)
      begin
        stats_store  <= ctrl[`CTRL_STATS_EN];
        memory_store <= ctrl[`CTRL_MEM_EN];
      end
      case (state)
        S_IDLE:
        begin
          if (cal_pend)
          begin
            cal_pend <= cal_fall;
            cal_busy <= 1'b1;
            count    <= ctrl[`CTRL_LINE_50HZ] ? CAL50 : CAL60;
            state    <= S_CAL;
          end
          else if (start)
          begin
            measure_go <= 1'b1;
            state      <= S_MEAS;
          end
        end
        S_MEAS:
          if (cmd_done)
            state <= S_IDLE;
        S_CAL:
        begin
          if (count <= 24'h00_0001)
          begin
            cal_busy <= 1'b0;
            state    <= S_IDLE;
          end
          else
            count <= count - 24'h00_0001;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // zero, print, probe check and lockout
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zero_go            <= 1'b0;
      print_go           <= 1'b0;
      probe_check_go     <= 1'b0;
      prb_pend           <= 1'b0;
      prb_wait           <= 1'b0;
      prb_count          <= {CW{1'b0}};
      panel_keys_enabled <= 1'b1;
      pin_trigger_mode   <= 1'b1;
    end
    else
    begin
      zero_go          <= zero_fall;
      print_go         <= rep_fall;
      panel_keys_enabled <= lock_lvl;
      pin_trigger_mode <= pin_mode;
      probe_check_go   <= 1'b0;
      if (prb_fall & ~busy)
        probe_check_go <= 1'b1;
      else if (prb_fall)
        prb_pend <= 1'b1;
      if (prb_pend & ~busy & ~prb_wait)
      begin
        prb_wait  <= 1'b1;
        prb_count <= PRBD;
      end
      if (prb_wait)
      begin
        if (prb_count <= 24'h00_0001)
        begin
          prb_wait       <= 1'b0;
          // a request arriving now while measuring must survive
          prb_pend       <= prb_fall & busy;
          probe_check_go <= 1'b1;
        end
        else
          prb_count <= prb_count - 24'h00_0001;
      end
    end
  end

  // result outputs, active low
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      measure_done_out             <= 1'b1;
      sampling_done_out            <= 1'b1;
      fault_out                    <= 1'b1;
      above_limit_out              <= 1'b1;
      in_limit_out                 <= 1'b1;
      under_limit_out              <= 1'b1;
      plus_side_contact_fault_out  <= 1'b1;
      minus_side_contact_fault_out <= 1'b1;
      probe_short_fault_out        <= 1'b1;
    end
    else
    begin
      measure_done_out  <= ~(busy & cmd_done);
      sampling_done_out <= ~(busy & wr_cmd & wb_dat_i[`CMD_SAMPLED]);
      // faults update with measure done, held
      if (busy & cmd_done)
      begin
        fault_out                    <= ~result[`RES_FAULT];
        plus_side_contact_fault_out  <= ~result[`RES_PLUS_CE];
        minus_side_contact_fault_out <= ~result[`RES_MINUS_CE];
        probe_short_fault_out        <= ~result[`RES_PROBE_SHORT];
        if (result[`RES_FAULT] | result[`RES_PLUS_CE] | result[`RES_MINUS_CE])
        begin
          above_limit_out <= 1'b1;
          in_limit_out    <= 1'b1;
          under_limit_out <= 1'b1;
        end
        else
        begin
          above_limit_out <= ~result[`RES_ABOVE];
          in_limit_out    <= ~result[`RES_IN_LIMIT];
          under_limit_out <= ~result[`RES_UNDER];
        end
      end
    end
  end
endmodule // ext_control_io

// ---- ext_io_defs.vh ----
// constants for the isolated external control port
`ifndef EXT_IO_DEFS_VH
`define EXT_IO_DEFS_VH
`define WB_AW            4
`define REG_CTRL         4'h0
`define REG_STATUS       4'h4
`define REG_RESULT       4'h8
`define REG_CMD          4'hC
`define CTRL_RESET       8'h00
`define CTRL_SELF_TIMED  0
`define CTRL_RISING      1
`define CTRL_STATS_EN    2
`define CTRL_MEM_EN      3
`define CTRL_MONITOR_EN  4
`define CTRL_LINE_50HZ   5
`define RES_IN_LIMIT     0
`define RES_ABOVE        1
`define RES_UNDER        2
`define RES_FAULT        3
`define RES_PLUS_CE      4
`define RES_MINUS_CE     5
`define RES_PROBE_SHORT  6
`define CMD_DONE         0
`define CMD_SAMPLED      1
`define CMD_MONITOR_ERR  2
`define CMD_MONITOR_CLR  3
`define CMD_CAL_DONE     4
`define CMD_ZERO_DONE    5
`define CLK_HZ           25000000
`define CAL_60HZ_MS      130
`define CAL_50HZ_MS      110
`define PRB_DELAY_MS     1
`endif

// ---- ext_io_edge.v ----
// two-flop synchroniser with falling and rising edge pulses
`timescale 1ns/1ps
module ext_io_edge
(
  input  wire clk,
  input  wire rst_n,
  input  wire pin,
  output reg  level,
  output wire fall,
  output wire rise
);
  reg meta;
  reg prev;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta  <= 1'b1;
      level <= 1'b1;
      prev  <= 1'b1;
    end
    else
    begin
      meta  <= pin;
      level <= meta;
      prev  <= level;
    end
  end
  assign fall = prev & ~level;
  assign rise = ~prev & level;
endmodule // ext_io_edge

// ---- ext_control_io_asserts.sv ----
// concurrent checks on the control port pins and its register bus
`timescale 1ns/1ps
module ext_control_io_asserts
(
  input wire clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire trigger_override_in_n,
  input wire panel_lock_in_n,
  input wire measure_done_out,
  input wire sampling_done_out,
  input wire fault_out,
  input wire above_limit_out,
  input wire in_limit_out,
  input wire under_limit_out,
  input wire plus_side_contact_fault_out,
  input wire minus_side_contact_fault_out,
  input wire probe_short_fault_out,
  input wire measure_go,
  input wire zero_go,
  input wire panel_keys_enabled,
  input wire pin_trigger_mode
);
  wire [6:0] res = {probe_short_fault_out, minus_side_contact_fault_out, plus_side_contact_fault_out,
                    fault_out, under_limit_out, above_limit_out, in_limit_out};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_done_pulse_low: assert property (!measure_done_out |=> measure_done_out)
    else $error("measure done not a single pulse");
  a_sampled_pulse_low: assert property (!sampling_done_out |=> sampling_done_out)
    else $error("sampling done not a single pulse");
  a_result_with_done: assert property (!$stable(res) |-> !measure_done_out)
    else $error("result pins changed without measure done");
  a_fault_clears_decisions: assert property ((res[5:3] != 3'h7) |-> (res[2:0] == 3'h7))
    else $error("decision asserted beside a fault");
  a_override_pin_mode: assert property (!trigger_override_in_n [*5] |-> pin_trigger_mode)
    else $error("override low without pin trigger mode");
  a_lock_blocks_keys: assert property (!panel_lock_in_n [*5] |-> !panel_keys_enabled)
    else $error("keys enabled while locked");
  a_go_single_pulse: assert property (measure_go |=> !measure_go)
    else $error("measure go repeated");
  a_go_needs_pin_mode: assert property (measure_go |-> pin_trigger_mode)
    else $error("measure go outside pin trigger mode");
  a_zero_single_pulse: assert property (zero_go |=> !zero_go)
    else $error("zero go repeated");
endmodule // ext_control_io_asserts

// ---- ext_plc_model.sv ----
// behavioural automation controller driving the control input pins
`timescale 1ns/1ps
module ext_plc_model
#(
  parameter ZERO_HOLD = 12
)
(
  input  wire clk,
  output wire measure_start_in_n,
  output wire trigger_override_in_n,
  output wire panel_lock_in_n,
  output wire zero_null_in,
  output wire report_request_in_n,
  output wire autotrim_request_in_n,
  output wire probe_short_test_in
);
  // pins idle high, as open optocoupler inputs
  reg [6:0] pin_n = 7'h7f;
  assign {probe_short_test_in, autotrim_request_in_n, report_request_in_n, zero_null_in,
          panel_lock_in_n, trigger_override_in_n, measure_start_in_n} = pin_n;
  task set_pin(input integer idx, input logic lvl);
    @(posedge clk);
    pin_n[idx] <= lvl;
  endtask
  // low request for len cycles, then release
  task strobe(input integer idx, input integer len);
    set_pin(idx, 1'b0);
    repeat (len) @(posedge clk);
    pin_n[idx] <= 1'b1;
  endtask
  // zero request held full span, scaled down to keep runs short
  task zero_request;
    strobe(3, ZERO_HOLD);
  endtask
endmodule // ext_plc_model

// ---- ext_control_io_tb_top.sv ----
// self-checking bench for the external control port
`timescale 1ns/1ps
module ext_control_io_tb_top;
  localparam CAL60 = 20;
  localparam CAL50 = 15;
  localparam PRB   = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] rdata;
  wire  [31:0] wb_dat_o;
  wire wb_ack_o, measure_start_in_n, trigger_override_in_n, panel_lock_in_n, zero_null_in;
  wire report_request_in_n, autotrim_request_in_n, probe_short_test_in;
  wire measure_done_out, sampling_done_out, fault_out, above_limit_out, in_limit_out;
  wire under_limit_out, plus_side_contact_fault_out, minus_side_contact_fault_out;
  wire probe_short_fault_out, measure_go, stats_store, memory_store, zero_go, print_go;
  wire cal_busy, probe_check_go, panel_keys_enabled, pin_trigger_mode;
  wire [6:0] pins = {probe_short_fault_out, minus_side_contact_fault_out, plus_side_contact_fault_out,
                     fault_out, under_limit_out, above_limit_out, in_limit_out};
  wire [8:0] ev = {!sampling_done_out, !measure_done_out, cal_busy, probe_check_go, print_go, zero_go,
                   memory_store, stats_store, measure_go};
  int cnt [9] = '{default:0};
  int base [9] = '{default:0};
  int num_errors = 0;
  int total_checks = 0;
  ext_control_io #(.CAL60_CYCLES(CAL60), .CAL50_CYCLES(CAL50), .PRB_CYCLES(PRB)) dut_u (.*);
  ext_plc_model plc_u (.*);
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    for (int k = 0; k < 9; k++)
      if (rst_n)
        cnt[k] <= cnt[k] + ev[k];
  end
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task events(input int k, input int n);
    check($sformatf("event count %0d", k), n, cnt[k] - base[k]);
  endtask
  task bit_is(input string what, input logic exp, input logic got);
    check(what, {31'h0, exp}, {31'h0, got});
  endtask
  task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1)
      @(posedge clk);
    rdata = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  // one falling request on the start pin, then count measurement starts
  task measure_start_in(input int n);
    base = cnt;
    plc_u.strobe(0, 6);
    repeat (8) @(posedge clk);
    events(0, n);
  endtask
  // fault or contact codes force the decisions high
  task finish_meas(input logic [6:0] res);
    logic [6:0] e;
    e = ~res;
    if (res[5:3] != 3'h0)
      e[2:0] = 3'h7;
    base = cnt;
    wb(1'b1, 4'h8, {25'h0, res});
    wb(1'b1, 4'hc, 32'h0000_0003);
    repeat (2) @(posedge clk);
    check("result pins", {25'h0, e}, {25'h0, pins});
    events(7, 1);
    events(8, 1);
  endtask
  task t_reset;
    wb(1'b0, 4'h0, 32'h0);
    check("ctrl", 32'h0000_0000, rdata);
    wb(1'b1, 4'h2, 32'h0000_00ff);
    wb(1'b0, 4'h2, 32'h0);
    check("unmapped", 32'h0000_0000, rdata);
    check("idle pins", 32'h0000_007f, {25'h0, pins});
    bit_is("pin mode", 1'b1, pin_trigger_mode);
    $display("test reset done");
  endtask
  task t_edges;
    wb(1'b1, 4'h0, 32'h0000_000c);
    measure_start_in(1);
    events(1, 1);
    events(2, 1);
    finish_meas(7'h02);
    wb(1'b1, 4'h0, 32'h0000_0002);
    base = cnt;
    plc_u.set_pin(0, 1'b0);
    repeat (8) @(posedge clk);
    events(0, 0);
    plc_u.set_pin(0, 1'b1);
    repeat (8) @(posedge clk);
    events(0, 1);
    finish_meas(7'h08);
    $display("test edges done");
  endtask
  task t_modes;
    wb(1'b1, 4'h0, 32'h0000_0009);
    @(posedge clk);
    bit_is("pin mode", 1'b0, pin_trigger_mode);
    measure_start_in(0);
    events(2, 1);
    plc_u.set_pin(1, 1'b0);
    repeat (6) @(posedge clk);
    bit_is("pin mode", 1'b1, pin_trigger_mode);
    measure_start_in(1);
    finish_meas(7'h01);
    plc_u.set_pin(1, 1'b1);
    repeat (6) @(posedge clk);
    bit_is("pin mode", 1'b0, pin_trigger_mode);
    wb(1'b1, 4'h0, 32'h0000_0010);
    wb(1'b1, 4'hc, 32'h0000_0004);
    measure_start_in(0);
    wb(1'b1, 4'hc, 32'h0000_0008);
    measure_start_in(1);
    finish_meas(7'h10);
    $display("test modes done");
  endtask
  task t_requests;
    base = cnt;
    plc_u.zero_request;
    plc_u.strobe(4, 6);
    repeat (8) @(posedge clk);
    events(3, 1);
    events(4, 1);
    wb(1'b1, 4'h0, 32'h0000_0000);
    measure_start_in(1);
    plc_u.strobe(5, 6);
    plc_u.strobe(6, 6);
    repeat (8) @(posedge clk);
    wb(1'b0, 4'h4, 32'h0);
    check("status", 32'h0000_00e2, rdata);
    events(6, 0);
    events(5, 0);
    finish_meas(7'h60);
    repeat (PRB / 2) @(posedge clk);
    events(5, 0);
    repeat (CAL60 + PRB) @(posedge clk);
    events(6, CAL60);
    events(5, 1);
    wb(1'b1, 4'h0, 32'h0000_0020);
    base = cnt;
    plc_u.strobe(5, 6);
    repeat (CAL50 + 12) @(posedge clk);
    events(6, CAL50);
    plc_u.set_pin(2, 1'b0);
    repeat (6) @(posedge clk);
    bit_is("keys", 1'b0, panel_keys_enabled);
    plc_u.set_pin(2, 1'b1);
    repeat (6) @(posedge clk);
    bit_is("keys", 1'b1, panel_keys_enabled);
    $display("test requests done");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_edges;
    t_modes;
    t_requests;
    summarize;
  end
  // whole run is well under a thousand cycles
  initial
  begin
    #(40 * 3000);
    num_errors++;
    summarize;
  end
endmodule // ext_control_io_tb_top
bind ext_control_io ext_control_io_asserts chk_u (.*);
